// *** design/tis_consts.svh ***
`ifndef TIS_CONSTS_SVH
`define TIS_CONSTS_SVH
// Register addresses on the register port.
`define TIS_ADDR_CTRL 6'h10
`define TIS_ADDR_CFG 6'h11
`define TIS_ADDR_STAT 6'h12
// Bit positions of the transmit status byte and of the matching enables.
`define TIS_BIT_LOWBAT 3'h6
`define TIS_BIT_NFULL 3'h5
`define TIS_BIT_HALF 3'h4
`define TIS_BIT_BERR 3'h2
`define TIS_BIT_TXC 3'h1
`define TIS_BIT_TXE 3'h0
// Self-clearing buffer clear bit in the control register.
`define TIS_BIT_CLR 3'h7
// Configuration register bits.
`define TIS_BIT_TXN 3'h0
`define TIS_BIT_ACK 3'h1
// Reset values.
`define TIS_RST_CTRL 8'h00
`define TIS_RST_CFG 8'h00
`define TIS_RST_FLAGS 8'h00
// Fill level thresholds in bytes still to be sent.
`define TIS_LVL_NFULL 5'h0F
`define TIS_LVL_HALF 5'h08
`define TIS_LVL_FULL 5'h10
`endif

// *** design/tis_pkg.sv ***
package tis_pkg;
  // One register byte.
  typedef logic [7:0] tis_byte_t;
  // Register port address.
  typedef logic [5:0] tis_addr_t;
endpackage : tis_pkg

// *** design/tis_irq_status.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tis_consts.svh"

// What this block does
// - Low-battery flag is forced off while the power management unit is off.
// - With power management on, the low-battery flag follows the comparator live.
// - Not-full flag is set while 15 or fewer bytes remain to send.
// - Half-empty flag is set while eight or fewer bytes remain to send.
// - Buffer error sets on underflow or full write; buffer clear resets it.
// - Outside transaction mode, complete sets right after the CRC ends.
// - In transaction mode, complete sets only when the transaction ends.
// - Reading the status register clears the complete flag.
// - Complete and error flags may update in different cycles for one event.
// - With auto acknowledge and an error, complete may stay unset.
// - A received acknowledge reports through the receive flags instead.
// - Low-battery flag is set when the supply is below the threshold and power management is on.
module tis_irq_status
  import tis_pkg::*;
#(
  parameter int LVL_W = 5
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire tis_addr_t reg_addr_i,
  input wire tis_byte_t reg_wdata_i,
  output tis_byte_t reg_rdata_o,
  input wire logic [LVL_W-1:0] tx_level_i,
  input wire logic tx_write_i,
  input wire logic tx_underflow_i,
  input wire logic crc_done_i,
  input wire logic txn_done_i,
  input wire logic tx_error_i,
  input wire logic ack_rx_i,
  input wire logic pmu_enable_i,
  input wire logic batt_low_i,
  output logic irq_o,
  output logic rx_complete_o,
  output logic rx_error_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  tis_byte_t ctrl_q, ctrl_d;
  tis_byte_t cfg_q, cfg_d;
  tis_byte_t flags_q, flags_d;
  tis_byte_t rdata_q, rdata_d;
  logic batt_s1_q, batt_s2_q;
  logic err_dly_q, err_dly_d;
  logic irq_q, irq_d;
  logic rxc_q, rxc_d;
  logic rxe_q, rxe_d;
  logic stat_rd, clr_pulse, txc_evt, txe_evt;
  logic txn_mode, ack_en;

  // Address match shared by the read and write decoders.
  function automatic logic addr_hit(input tis_addr_t a, input tis_addr_t r);
    addr_hit = (a == r);
  endfunction : addr_hit

  //////////////////////////////////////////////////////////////////////////////
  // Event decode.

  // The comparator is analog and asynchronous, so it is synchronised first.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      batt_s1_q <= 1'b0;
      batt_s2_q <= 1'b0;
    end else begin
      batt_s1_q <= batt_low_i;
      batt_s2_q <= batt_s1_q;
    end
  end

  // Strobes and event qualification.
  always_comb begin
    txn_mode = cfg_q[`TIS_BIT_TXN];
    ack_en = cfg_q[`TIS_BIT_ACK];
    stat_rd = reg_rd_i && addr_hit(reg_addr_i, `TIS_ADDR_STAT);
    clr_pulse = reg_wr_i && addr_hit(reg_addr_i, `TIS_ADDR_CTRL) &&
                reg_wdata_i[`TIS_BIT_CLR];
    // A received acknowledge goes to the receive side.
    txc_evt = !ack_rx_i && (txn_mode ?
              (txn_done_i && !(ack_en && tx_error_i)) :
              crc_done_i);
    txe_evt = tx_error_i && !ack_rx_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register writes.

  // Control keeps the enables; the clear bit is a pulse and reads zero.
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    if (reg_wr_i && addr_hit(reg_addr_i, `TIS_ADDR_CTRL)) begin
      ctrl_d = {1'b0, reg_wdata_i[6:0]};
    end else if (reg_wr_i && addr_hit(reg_addr_i, `TIS_ADDR_CFG)) begin
      cfg_d = {6'h00, reg_wdata_i[1:0]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `TIS_RST_CTRL;
      cfg_q <= `TIS_RST_CFG;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags.

  // Sticky flags: a set in the clearing cycle wins over the clear.
  always_comb begin
    flags_d = flags_q;
    // The error flag lands two cycles after its event.
    err_dly_d = txe_evt;
    flags_d[`TIS_BIT_LOWBAT] = pmu_enable_i && batt_s2_q;
    flags_d[`TIS_BIT_NFULL] = (tx_level_i <= `TIS_LVL_NFULL);
    flags_d[`TIS_BIT_HALF] = (tx_level_i <= `TIS_LVL_HALF);
    if (clr_pulse) begin
      flags_d[`TIS_BIT_BERR] = 1'b0;
    end
    if (tx_underflow_i || (tx_write_i && tx_level_i == `TIS_LVL_FULL)) begin
      flags_d[`TIS_BIT_BERR] = 1'b1;
    end
    if (stat_rd) begin
      flags_d[`TIS_BIT_TXC] = 1'b0;
      flags_d[`TIS_BIT_TXE] = 1'b0;
    end
    if (txc_evt) begin
      flags_d[`TIS_BIT_TXC] = 1'b1;
    end
    if (err_dly_q) begin
      flags_d[`TIS_BIT_TXE] = 1'b1;
    end
    flags_d[7] = 1'b0;
    flags_d[3] = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      flags_q <= `TIS_RST_FLAGS;
      err_dly_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      err_dly_q <= err_dly_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Read data, interrupt and receive-side reports, all registered.
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_i && addr_hit(reg_addr_i, `TIS_ADDR_STAT)) begin
      rdata_d = flags_q;
    end else if (reg_rd_i && addr_hit(reg_addr_i, `TIS_ADDR_CTRL)) begin
      rdata_d = ctrl_q;
    end else if (reg_rd_i && addr_hit(reg_addr_i, `TIS_ADDR_CFG)) begin
      rdata_d = cfg_q;
    end else if (reg_rd_i) begin
      rdata_d = 8'h00;
    end else begin
      rdata_d = rdata_q;
    end
    irq_d = |(flags_q & ctrl_q & 8'h7F);
    rxc_d = ack_rx_i && (txn_done_i || crc_done_i);
    rxe_d = ack_rx_i && tx_error_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      rxc_q <= 1'b0;
      rxe_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      rxc_q <= rxc_d;
      rxe_q <= rxe_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign rx_complete_o = rxc_q;
  assign rx_error_o = rxe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Power management off keeps the low-battery flag clear.
  a_lowbat_pmu_off: assert property (
    !pmu_enable_i |=> !flags_q[`TIS_BIT_LOWBAT])
    else $error("Low-battery flag set with power management off.");

  // The flag tracks the synchronised comparator, low going as well as high.
  a_lowbat_follows: assert property (
    pmu_enable_i && $past(pmu_enable_i) && !batt_low_i ##1 pmu_enable_i
    ##1 pmu_enable_i |=> !flags_q[`TIS_BIT_LOWBAT])
    else $error("Low-battery flag latched instead of following.");

  // Not-full flag matches the fill level one cycle later.
  a_nfull_level: assert property (
    ##1 flags_q[`TIS_BIT_NFULL] == ($past(tx_level_i) <= 5'h0F))
    else $error("Not-full flag disagrees with fill level.");

  // Half-empty flag matches the fill level one cycle later.
  a_half_level: assert property (
    ##1 flags_q[`TIS_BIT_HALF] == ($past(tx_level_i) <= 5'h08))
    else $error("Half-empty flag disagrees with fill level.");

  // Underflow sets the error flag; a clear alone removes it.
  a_berr_set: assert property (
    tx_underflow_i |=> flags_q[`TIS_BIT_BERR])
    else $error("Buffer error not set on underflow.");
  a_berr_clear: assert property (
    clr_pulse && !tx_underflow_i && !tx_write_i |=> !flags_q[`TIS_BIT_BERR])
    else $error("Buffer error not cleared by buffer clear.");

  // Outside transaction mode the CRC end sets complete next cycle.
  a_txc_crc: assert property (
    !cfg_q[`TIS_BIT_TXN] && crc_done_i && !ack_rx_i |=> flags_q[`TIS_BIT_TXC])
    else $error("Complete flag missed after CRC end.");

  // In transaction mode the CRC end alone does not set complete.
  a_txc_txn_only: assert property (
    cfg_q[`TIS_BIT_TXN] && !txn_done_i && !stat_rd && !flags_q[`TIS_BIT_TXC]
    |=> !flags_q[`TIS_BIT_TXC])
    else $error("Complete flag set before transaction end.");

  // A status read without a new event clears complete.
  a_txc_read_clr: assert property (
    stat_rd && !txc_evt |=> !flags_q[`TIS_BIT_TXC])
    else $error("Status read did not clear complete flag.");

  // The error flag appears two cycles after its event, not before.
  a_txe_late: assert property (
    tx_error_i && !ack_rx_i && !flags_q[`TIS_BIT_TXE] && !stat_rd && !err_dly_q
    |=> !flags_q[`TIS_BIT_TXE] ##1 flags_q[`TIS_BIT_TXE])
    else $error("Error flag timing wrong.");

  // A received acknowledge with an error reports on rx_error_o.
  a_ack_to_rx: assert property (
    ack_rx_i && tx_error_i |=> rx_error_o)
    else $error("Acknowledge error not routed to receive side.");

  // Interrupt follows enabled flags one cycle later.
  a_irq_enabled: assert property (
    ##1 irq_o == |($past(flags_q) & $past(ctrl_q) & 8'h7F))
    else $error("Interrupt output disagrees with enabled flags.");

endmodule : tis_irq_status

`default_nettype wire

// *** verification/tis_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tis_consts.svh"
// Host firmware model that reaches the status logic over the register port.
module tis_host_model
  import tis_pkg::*;
(
  input wire logic sys_clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output tis_addr_t reg_addr_o,
  output tis_byte_t reg_wdata_o,
  input wire tis_byte_t reg_rdata_i
);
  // Port idles with strobes low at time zero.
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 6'h00;
    reg_wdata_o = 8'h00;
  end
  // One write; address and data are scrambled once released.
  task wr_reg(input tis_addr_t a, input tis_byte_t d);
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr_reg
  // One read; data is taken once the registered answer has landed.
  task rd_reg(input tis_addr_t a, output tis_byte_t d);
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    // The answer stands until the next read, so the next edge is safe.
    @(posedge sys_clk_i);
    d = reg_rdata_i;
  endtask : rd_reg
  // Second read only when complete came without error.
  task poll_status(output tis_byte_t s);
    tis_byte_t t;
    rd_reg(`TIS_ADDR_STAT, s);
    if (s[1:0] == 2'h2) begin
      rd_reg(`TIS_ADDR_STAT, t);
      s[0] = t[0];
    end
  endtask : poll_status
endmodule : tis_host_model
`default_nettype wire

// *** verification/tis_irq_status_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tis_consts.svh"
module tis_irq_status_bench
  import tis_pkg::*;
;
  logic sys_clk = 1'b0, srst = 1'b1, wr, rd, txw = 1'b0, und = 1'b0;
  logic crc = 1'b0, txn = 1'b0, err = 1'b0, ack = 1'b0, power_management_unit = 1'b0;
  logic batt = 1'b0, irq, rxc, rxe, seen;
  tis_addr_t addr;
  tis_byte_t wdata, rdata, s;
  logic [4:0] lvl = 5'h10;
  int n_errors = 0, cmp_count = 0;
  logic [4:0] lv_tab [5] = '{5'h10, 5'h0F, 5'h09, 5'h08, 5'h00};
  tis_byte_t ex_tab [5] = '{8'h00, 8'h20, 8'h20, 8'h30, 8'h30};
  // Clock at 50 MHz.
  always #10 sys_clk = ~sys_clk;
  tis_irq_status tis_irq_status_i (.sys_clk_i(sys_clk), .srst_i(srst),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .tx_level_i(lvl), .tx_write_i(txw),
    .tx_underflow_i(und), .crc_done_i(crc), .txn_done_i(txn),
    .tx_error_i(err), .ack_rx_i(ack), .pmu_enable_i(power_management_unit),
    .batt_low_i(batt), .irq_o(irq), .rx_complete_o(rxc),
    .rx_error_o(rxe));
  tis_host_model tis_host_model_i (.sys_clk_i(sys_clk), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_rdata_i(rdata));
  ////////////////////////////////////////////////////////////////////////////
  // Byte compare with counting.
  task chk(input tis_byte_t g, input tis_byte_t e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One-cycle event pulse: write, underflow, crc, transaction, error.
  task ev(input logic [4:0] v);
    @(posedge sys_clk);
    {txw, und, crc, txn, err} <= v;
    @(posedge sys_clk);
    {txw, und, crc, txn, err} <= 5'h00;
  endtask : ev
  // Catches a pulse on rx complete (0), interrupt (1) or rx error (2).
  // Samples between edges, then returns on a rising edge for the stimulus.
  task catch_out(input logic [1:0] sel);
    seen = 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      seen = seen | (sel == 2'h1 ? irq : (sel == 2'h2 ? rxe : rxc));
    end
    @(posedge sys_clk);
  endtask : catch_out
  task print_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, `TIS_RST_FLAGS);
    for (int i = 0; i < 5; i++) begin
      lvl <= lv_tab[i];
      repeat (3) @(posedge sys_clk);
      tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
      chk(s & 8'h30, ex_tab[i]);
    end
    lvl <= 5'h10;
    ev(5'h10);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h04);
    tis_host_model_i.wr_reg(`TIS_ADDR_CTRL, 8'h80);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    ev(5'h08);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h04);
    tis_host_model_i.wr_reg(`TIS_ADDR_CTRL, 8'h80);
    ev(5'h05);
    repeat (3) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h03);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    tis_host_model_i.wr_reg(`TIS_ADDR_CFG, 8'h01);
    ev(5'h04);
    repeat (3) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    ev(5'h03);
    tis_host_model_i.poll_status(s);
    chk(s, 8'h03);
    // The first read lands after complete but before the late error flag.
    fork
      ev(5'h03);
      begin
        @(posedge sys_clk);
        tis_host_model_i.poll_status(s);
      end
    join
    chk(s, 8'h03);
    tis_host_model_i.wr_reg(`TIS_ADDR_CFG, 8'h03);
    ev(5'h03);
    repeat (3) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s & 8'h02, 8'h00);
    tis_host_model_i.wr_reg(`TIS_ADDR_CFG, 8'h00);
    ack <= 1'b1;
    ev(5'h04);
    catch_out(2'h0);
    chk({7'h00, seen}, 8'h01);
    ev(5'h01);
    catch_out(2'h2);
    chk({7'h00, seen}, 8'h01);
    ack <= 1'b0;
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    tis_host_model_i.wr_reg(`TIS_ADDR_CTRL, 8'h02);
    ev(5'h04);
    catch_out(2'h1);
    chk({7'h00, seen}, 8'h01);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h00);
    power_management_unit <= 1'b1;
    batt <= 1'b1;
    repeat (6) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h40);
    batt <= 1'b0;
    repeat (6) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    batt <= 1'b1;
    power_management_unit <= 1'b0;
    repeat (6) @(posedge sys_clk);
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, 8'h00);
    // A reset in mid-run drops a pending buffer error and the enables.
    ev(5'h08);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    tis_host_model_i.rd_reg(`TIS_ADDR_STAT, s);
    chk(s, `TIS_RST_FLAGS);
    tis_host_model_i.rd_reg(`TIS_ADDR_CTRL, s);
    chk(s, `TIS_RST_CTRL);
    print_verdict();
  end
endmodule : tis_irq_status_bench
`default_nettype wire
